// ==== rtl/rcr_defs.svh ====
// Constants of the receiver configuration store: field positions, reset values, timing counts.
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// ----------------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------------
// Serial bit n lands at shift index (15 - n); bit 1 arrives first.
`define RCR_WORD_BITS     15
`define RCR_POS_OFF       14
`define RCR_POS_SEL       13
`define RCR_POS_STOP      0
`define RCR_PAY_HI        12
`define RCR_PAY_LO        1

// ----------------------------------------------------------------------------
// Reset values of both registers
// ----------------------------------------------------------------------------
// Baud 00, check 01, FSK, sleep 00110, multiplier 0, squelch 1.
`define RCR_OPERATING_CONFIG_WORD_RST    12'h119
// Lower window 010101, upper window 101001.
`define RCR_LIMIT_RST     12'h569

// ----------------------------------------------------------------------------
// Sleep timing
// ----------------------------------------------------------------------------
`define RCR_SLEEP_UNIT_LOG2  10
`define RCR_SLEEP_XMUL_LOG2  3
`define RCR_SLEEP_PERM       5'h1F
`define RCR_SLEEP_NONE       5'h00

// ----------------------------------------------------------------------------
// Timebase divider default
// ----------------------------------------------------------------------------
`define RCR_TCLK_DIV      8

`endif

// ==== rtl/rcr_pkg.sv ====
// Types shared by the receiver configuration store and its sleep timer.
package rcr_pkg;

	// Operating configuration word, most significant field first.
	typedef struct packed {
		logic [1:0] baud_range_select;
		logic [1:0] bit_verify_code;
		logic       modulation_select;
		logic [4:0] sleep_count;
		logic       sleep_multiplier;
		logic       squelch_enable;
	} rcr_operating_config_word_t;

	// Edge window limit word.
	typedef struct packed {
		logic [5:0] lower_window;
		logic [5:0] upper_window;
	} rcr_limit_t;

	// Sleep timer states.
	typedef enum logic [2:0] {
		RCR_SLP_IDLE = 3'b001,
		RCR_SLP_RUN  = 3'b010,
		RCR_SLP_PERM = 3'b100
	} rcr_sleep_state_t;

endpackage

// ==== rtl/rcr_sleep_timer.sv ====
// Sleep timer that spaces the polling cycles of the receiver.
`timescale 1ns/100ps
`include "rcr_defs.svh"

module rcr_sleep_timer (
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       tick_i,
	input  wire logic       start_i,
	input  wire logic       abort_i,
	input  wire logic [4:0] sleep_count_i,
	input  wire logic       sleep_multiplier_i,
	output logic            sleeping_o,
	output logic            poll_start_o
);

	rcr_pkg::rcr_sleep_state_t state_r;
	rcr_pkg::rcr_sleep_state_t state_nxt;
	logic [17:0]               cnt_r;
	logic [17:0]               cnt_nxt;
	logic                      sleeping_nxt;
	logic                      poll_nxt;
	logic [17:0]               load_val;

	// Total ticks are count times multiplier times the unit.
	always_comb begin
		load_val = {3'h0, 5'h00, 10'h000};
		load_val[`RCR_SLEEP_UNIT_LOG2 +: 5] = sleep_count_i;
		if (sleep_multiplier_i) begin
			load_val = load_val << `RCR_SLEEP_XMUL_LOG2;
		end
	end

	// Next-state logic of the timer.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		poll_nxt  = 1'b0;
		case (state_r)
			rcr_pkg::RCR_SLP_IDLE: begin
				if (start_i && !abort_i) begin
					if (sleep_count_i == `RCR_SLEEP_NONE) begin
						poll_nxt = 1'b1;
					end else if (sleep_count_i == `RCR_SLEEP_PERM) begin
						state_nxt = rcr_pkg::RCR_SLP_PERM;
					end else begin
						state_nxt = rcr_pkg::RCR_SLP_RUN;
						cnt_nxt   = load_val;
					end
				end
			end
			rcr_pkg::RCR_SLP_RUN: begin
				if (abort_i) begin
					state_nxt = rcr_pkg::RCR_SLP_IDLE;
				end else if (tick_i) begin
					cnt_nxt = cnt_r - 18'h00001;
					if (cnt_r == 18'h00001) begin
						state_nxt = rcr_pkg::RCR_SLP_IDLE;
						poll_nxt  = 1'b1;
					end
				end
			end
			rcr_pkg::RCR_SLP_PERM: begin
				// Only an outside abort leaves permanent sleep.
				if (abort_i) begin
					state_nxt = rcr_pkg::RCR_SLP_IDLE;
				end
			end
			default: begin
				state_nxt = rcr_pkg::RCR_SLP_IDLE;
			end
		endcase
		sleeping_nxt = (state_nxt != rcr_pkg::RCR_SLP_IDLE);
	end

	// Timer registers.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r      <= rcr_pkg::RCR_SLP_IDLE;
			cnt_r        <= 18'h00000;
			sleeping_o   <= 1'b0;
			poll_start_o <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			cnt_r        <= cnt_nxt;
			sleeping_o   <= sleeping_nxt;
			poll_start_o <= poll_nxt;
		end
	end

endmodule

// ==== rtl/rcr_config_top.sv ====
// Configuration store and field decode of the polling receiver.
//
// How it works
// - Operating word fields from bits 3-14.
// - Limit word: two six-bit windows, MSB first.
// - Defaults as listed for every field.
// - Baud range also sets limit scale.
// - Scale 8, 4, 2, 1 per code.
// - Time limits from scale and windows.
// - Checked bits 0, 3, 6 or 9.
// - Modulation 0 FSK, 1 ASK.
// - Sleep = count times multiplier times 1024.
// - Count zero polls continuously.
// - Count 31 means permanent sleep.
// - Multiplier bit gives 1 or 8.
// - Squelch bit enables noise suppression.
// - Squelch: stream end returns to bit check.
// - Bit 1 off command; bit 2 selects register.
// - Commit only when bit 15 is 0.
// - Reset loads both registers with defaults.
`timescale 1ns/100ps
`include "rcr_defs.svh"

module rcr_config_top #(
	parameter int TCLK_DIV = `RCR_TCLK_DIV
) (
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       word_start_i,
	input  wire logic       bit_valid_i,
	input  wire logic       bit_value_i,
	input  wire logic       poll_done_i,
	input  wire logic       stream_end_i,
	input  wire logic       bit_check_ok_i,
	output logic [1:0]      baud_range_select_o,
	output logic [3:0]      limit_scale_factor_o,
	output logic [3:0]      bit_verify_count_o,
	output logic            modulation_select_o,
	output logic [4:0]      sleep_count_o,
	output logic [3:0]      sleep_factor_o,
	output logic            squelch_enable_o,
	output logic [5:0]      lower_window_o,
	output logic [5:0]      upper_window_o,
	output logic [8:0]      lim_min_time_o,
	output logic [8:0]      lim_max_time_o,
	output logic            off_cmd_o,
	output logic            word_accept_o,
	output logic            rx_mode_o,
	output logic            data_hold_high_o,
	output logic            sleeping_o,
	output logic            poll_start_o,
	output logic            tick_o
);

	// ------------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------------
	if (TCLK_DIV < 1 || TCLK_DIV > 65535) begin : g_bad_div
		$error("TCLK_DIV must lie between 1 and 65535");
	end

	// ------------------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------------------
	// Limit scale factor from the baud range code.
	function automatic logic [3:0] scale_of(input logic [1:0] code);
		case (code)
			2'h0:    scale_of = 4'h8;
			2'h1:    scale_of = 4'h4;
			2'h2:    scale_of = 4'h2;
			default: scale_of = 4'h1;
		endcase
	endfunction

	// Number of bits verified before receive.
	function automatic logic [3:0] verify_of(input logic [1:0] code);
		case (code)
			2'h0:    verify_of = 4'h0;
			2'h1:    verify_of = 4'h3;
			2'h2:    verify_of = 4'h6;
			default: verify_of = 4'h9;
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// Timebase divider
	// ------------------------------------------------------------------------
	logic [15:0] div_r;
	logic [15:0] div_nxt;
	logic        tick_nxt;

	// Makes one enable pulse per receiver timebase period.
	always_comb begin
		tick_nxt = (div_r == 16'(TCLK_DIV - 1));
		div_nxt  = tick_nxt ? 16'h0000 : div_r + 16'h0001;
	end

	// Divider registers.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_r  <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			tick_o <= tick_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Serial word collection
	// ------------------------------------------------------------------------
	logic [14:0] shift_r;
	logic [14:0] shift_nxt;
	logic [3:0]  count_r;
	logic [3:0]  count_nxt;
	logic        done;
	logic        off_nxt;
	logic        accept_nxt;
	logic        load_op;
	logic        load_lim;

	// Shifts bits in, first bit ending at the top; a start restarts the word.
	always_comb begin
		shift_nxt = shift_r;
		count_nxt = count_r;
		done      = 1'b0;
		if (word_start_i) begin
			count_nxt = 4'h0;
		end else if (bit_valid_i) begin
			shift_nxt = {shift_r[13:0], bit_value_i};
			if (count_r == 4'(`RCR_WORD_BITS - 1)) begin
				count_nxt = 4'h0;
				done      = 1'b1;
			end else begin
				count_nxt = count_r + 4'h1;
			end
		end
	end

	// Classifies a finished word.
	always_comb begin
		off_nxt  = done && shift_nxt[`RCR_POS_OFF];
		accept_nxt = done && !shift_nxt[`RCR_POS_OFF] && !shift_nxt[`RCR_POS_STOP];
		load_op  = accept_nxt && shift_nxt[`RCR_POS_SEL];
		load_lim = accept_nxt && !shift_nxt[`RCR_POS_SEL];
	end

	// Collector registers.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			shift_r       <= 15'h0000;
			count_r       <= 4'h0;
			off_cmd_o     <= 1'b0;
			word_accept_o <= 1'b0;
		end else begin
			shift_r       <= shift_nxt;
			count_r       <= count_nxt;
			off_cmd_o     <= off_nxt;
			word_accept_o <= accept_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------
	rcr_pkg::rcr_operating_config_word_t op_r;
	rcr_pkg::rcr_operating_config_word_t op_nxt;
	rcr_pkg::rcr_limit_t  lim_r;
	rcr_pkg::rcr_limit_t  lim_nxt;
	logic [3:0]           scale_nxt;
	logic [8:0]           tmin_nxt;
	logic [8:0]           tmax_nxt;

	// Loads one whole register at a time and derives the decoded values.
	always_comb begin
		op_nxt  = op_r;
		lim_nxt = lim_r;
		if (load_op) begin
			op_nxt = rcr_pkg::rcr_operating_config_word_t'(shift_nxt[`RCR_PAY_HI:`RCR_PAY_LO]);
		end
		if (load_lim) begin
			lim_nxt = rcr_pkg::rcr_limit_t'(shift_nxt[`RCR_PAY_HI:`RCR_PAY_LO]);
		end
		scale_nxt = scale_of(op_nxt.baud_range_select);
		tmin_nxt  = 9'(lim_nxt.lower_window) * 9'(scale_nxt);
		tmax_nxt  = 9'(lim_nxt.upper_window - 6'h01) * 9'(scale_nxt);
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			op_r                 <= rcr_pkg::rcr_operating_config_word_t'(`RCR_OPERATING_CONFIG_WORD_RST);
			lim_r                <= rcr_pkg::rcr_limit_t'(`RCR_LIMIT_RST);
			baud_range_select_o  <= 2'h0;
			limit_scale_factor_o <= 4'h8;
			bit_verify_count_o   <= 4'h3;
			modulation_select_o  <= 1'b0;
			sleep_count_o        <= 5'h06;
			sleep_factor_o       <= 4'h1;
			squelch_enable_o     <= 1'b1;
			lower_window_o       <= 6'h15;
			upper_window_o       <= 6'h29;
			lim_min_time_o       <= 9'h0A8;
			lim_max_time_o       <= 9'h140;
		end else begin
			op_r                 <= op_nxt;
			lim_r                <= lim_nxt;
			baud_range_select_o  <= op_nxt.baud_range_select;
			limit_scale_factor_o <= scale_nxt;
			bit_verify_count_o   <= verify_of(op_nxt.bit_verify_code);
			modulation_select_o  <= op_nxt.modulation_select;
			sleep_count_o        <= op_nxt.sleep_count;
			sleep_factor_o       <= op_nxt.sleep_multiplier ? 4'h8 : 4'h1;
			squelch_enable_o     <= op_nxt.squelch_enable;
			lower_window_o       <= lim_nxt.lower_window;
			upper_window_o       <= lim_nxt.upper_window;
			lim_min_time_o       <= tmin_nxt;
			lim_max_time_o       <= tmax_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Noise squelch mode control
	// ------------------------------------------------------------------------
	logic rx_nxt;
	logic hold_nxt;

	// Returns to bit check at stream end while squelch is on.
	always_comb begin
		rx_nxt   = rx_mode_o;
		hold_nxt = data_hold_high_o;
		if (stream_end_i && op_r.squelch_enable && rx_mode_o) begin
			rx_nxt   = 1'b0;
			hold_nxt = 1'b1;
		end else if (bit_check_ok_i) begin
			rx_nxt   = 1'b1;
			hold_nxt = 1'b0;
		end else if (off_cmd_o) begin
			rx_nxt   = 1'b0;
			hold_nxt = 1'b0;
		end
	end

	// Mode registers.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_mode_o        <= 1'b0;
			data_hold_high_o <= 1'b0;
		end else begin
			rx_mode_o        <= rx_nxt;
			data_hold_high_o <= hold_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Sleep timer
	// ------------------------------------------------------------------------
	// sleep spacing
	rcr_sleep_timer u_sleep (
		.sys_clk_i          (sys_clk_i),
		.sys_rst_i          (sys_rst_i),
		.tick_i             (tick_o),
		.start_i            (poll_done_i),
		.abort_i            (off_cmd_o | word_accept_o),
		.sleep_count_i      (op_r.sleep_count),
		.sleep_multiplier_i (op_r.sleep_multiplier),
		.sleeping_o         (sleeping_o),
		.poll_start_o       (poll_start_o)
	);

endmodule

// ==== tb/rcr_config_monitor.sv ====
// Checker of the receiver configuration store, bound to its top module.
`timescale 1ns/100ps

module rcr_config_monitor (
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       poll_done_i,
	input  wire logic       stream_end_i,
	input  wire logic [1:0] baud_range_select_o,
	input  wire logic [3:0] limit_scale_factor_o,
	input  wire logic [3:0] bit_verify_count_o,
	input  wire logic       modulation_select_o,
	input  wire logic [4:0] sleep_count_o,
	input  wire logic [3:0] sleep_factor_o,
	input  wire logic       squelch_enable_o,
	input  wire logic [5:0] lower_window_o,
	input  wire logic [5:0] upper_window_o,
	input  wire logic [8:0] lim_min_time_o,
	input  wire logic [8:0] lim_max_time_o,
	input  wire logic       off_cmd_o,
	input  wire logic       word_accept_o,
	input  wire logic       rx_mode_o,
	input  wire logic       data_hold_high_o,
	input  wire logic       sleeping_o,
	input  wire logic       poll_start_o
);
	// All configuration fields in one vector, so a stray change shows at once.
	logic [28:0] cfg;
	logic        idle_req;
	assign cfg = {baud_range_select_o, bit_verify_count_o, modulation_select_o, sleep_count_o,
		sleep_factor_o, squelch_enable_o, lower_window_o, upper_window_o};
	assign idle_req = poll_done_i && !sleeping_o && !off_cmd_o && !word_accept_o;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_scale_map: assert property (limit_scale_factor_o == (4'h8 >> baud_range_select_o))
		else $error("scale factor does not follow baud code");
	chk_verify_set: assert property (bit_verify_count_o inside {4'h0, 4'h3, 4'h6, 4'h9})
		else $error("bad checked bit count");
	chk_factor_set: assert property (sleep_factor_o == 4'h1 || sleep_factor_o == 4'h8)
		else $error("bad sleep factor");
	chk_min_time: assert property (lim_min_time_o == 9'(lower_window_o) * 9'(limit_scale_factor_o))
		else $error("lower time limit wrong");
	chk_max_time: assert property (lim_max_time_o == (9'(upper_window_o) - 9'h001) * 9'(limit_scale_factor_o))
		else $error("upper time limit wrong");
	chk_cfg_hold: assert property (!word_accept_o |-> $stable(cfg))
		else $error("fields changed without accepted word");
	chk_off_keeps: assert property (off_cmd_o |-> !word_accept_o && $stable(cfg))
		else $error("off command touched registers");
	chk_squelch_end: assert property (stream_end_i && rx_mode_o && squelch_enable_o |=> !rx_mode_o && data_hold_high_o)
		else $error("stream end not squelched");
	chk_hold_rx: assert property (data_hold_high_o |-> !rx_mode_o)
		else $error("data held high while receiving");
	chk_sleep_zero: assert property (idle_req && sleep_count_o == 5'h00 |=> poll_start_o && !sleeping_o)
		else $error("zero sleep did not poll at once");
	chk_sleep_perm: assert property (idle_req && sleep_count_o == 5'h1F |=> sleeping_o && !poll_start_o)
		else $error("permanent sleep not entered");
	chk_sleep_start: assert property (idle_req && sleep_count_o inside {[1:30]} |=> sleeping_o && !poll_start_o)
		else $error("sleep not started");
endmodule

bind rcr_config_top rcr_config_monitor mon_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.poll_done_i(poll_done_i), .stream_end_i(stream_end_i), .off_cmd_o(off_cmd_o),
	.baud_range_select_o(baud_range_select_o), .limit_scale_factor_o(limit_scale_factor_o),
	.bit_verify_count_o(bit_verify_count_o), .modulation_select_o(modulation_select_o),
	.sleep_count_o(sleep_count_o), .sleep_factor_o(sleep_factor_o), .rx_mode_o(rx_mode_o),
	.squelch_enable_o(squelch_enable_o), .lower_window_o(lower_window_o),
	.upper_window_o(upper_window_o), .lim_min_time_o(lim_min_time_o), .sleeping_o(sleeping_o),
	.lim_max_time_o(lim_max_time_o), .word_accept_o(word_accept_o), .poll_start_o(poll_start_o),
	.data_hold_high_o(data_hold_high_o));

// ==== tb/rcr_host_model.sv ====
// Host controller model that programs the receiver one serial bit at a time.
`timescale 1ns/100ps

module rcr_host_model (
	input  wire logic sys_clk_i,
	output logic      word_start_o,
	output logic      bit_valid_o,
	output logic      bit_value_o
);
	// The data line has a pull-up, so it idles high between bits.
	initial begin
		word_start_o = 1'b0;
		bit_valid_o  = 1'b0;
		bit_value_o  = 1'b1;
	end

	// Sends bit 1 first with up to max_gap idle cycles after each bit.
	// command, select, stop
	task automatic send(input logic [14:0] word, input int max_gap);
		int gap;
		@(negedge sys_clk_i);
		word_start_o = 1'b1;
		@(negedge sys_clk_i);
		word_start_o = 1'b0;
		for (int i = 14; i >= 0; i--) begin
			bit_valid_o = 1'b1;
			bit_value_o = word[i];
			@(negedge sys_clk_i);
			gap = $urandom_range(max_gap);
			if (gap != 0) begin
				bit_valid_o = 1'b0;
				bit_value_o = 1'b1;
				repeat (gap) @(negedge sys_clk_i);
			end
		end
		bit_valid_o = 1'b0;
		bit_value_o = 1'b1;
	endtask
endmodule

// ==== tb/tb_receiver_config_registers.sv ====
// Self-checking testbench of the receiver configuration store.
`timescale 1ns/100ps

module tb_receiver_config_registers;
	logic                 sys_clk_i, sys_rst_i, word_start_i, bit_valid_i, bit_value_i;
	logic                 poll_done_i, stream_end_i, bit_check_ok_i, off_cmd_o, word_accept_o;
	logic                 rx_mode_o, data_hold_high_o, sleeping_o, poll_start_o, tick_o;
	logic                 modulation_select_o, squelch_enable_o;
	logic [1:0]           baud_range_select_o;
	logic [3:0]           limit_scale_factor_o, bit_verify_count_o, sleep_factor_o;
	logic [4:0]           sleep_count_o;
	logic [5:0]           lower_window_o, upper_window_o;
	logic [8:0]           lim_min_time_o, lim_max_time_o;
	logic [51:0]          seen;
	logic [51:0]          exp_q[$];
	int                   failures, checks_done, n;
	rcr_pkg::rcr_operating_config_word_t op_m;
	rcr_pkg::rcr_limit_t  lim_m;

	// The bench runs the timebase at the clock rate to keep sleep times short.
	rcr_config_top #(.TCLK_DIV(1)) dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.word_start_i(word_start_i), .bit_valid_i(bit_valid_i), .bit_value_i(bit_value_i),
		.poll_done_i(poll_done_i), .stream_end_i(stream_end_i), .bit_check_ok_i(bit_check_ok_i),
		.baud_range_select_o(baud_range_select_o), .limit_scale_factor_o(limit_scale_factor_o),
		.bit_verify_count_o(bit_verify_count_o), .modulation_select_o(modulation_select_o),
		.sleep_count_o(sleep_count_o), .sleep_factor_o(sleep_factor_o),
		.squelch_enable_o(squelch_enable_o), .lower_window_o(lower_window_o),
		.upper_window_o(upper_window_o), .lim_min_time_o(lim_min_time_o),
		.lim_max_time_o(lim_max_time_o), .off_cmd_o(off_cmd_o), .word_accept_o(word_accept_o),
		.rx_mode_o(rx_mode_o), .data_hold_high_o(data_hold_high_o), .sleeping_o(sleeping_o),
		.poll_start_o(poll_start_o), .tick_o(tick_o));

	rcr_host_model host_u (.sys_clk_i(sys_clk_i), .word_start_o(word_start_i),
		.bit_valid_o(bit_valid_i), .bit_value_o(bit_value_i));

	assign seen = {off_cmd_o, baud_range_select_o, limit_scale_factor_o, bit_verify_count_o,
		modulation_select_o, sleep_count_o, sleep_factor_o, squelch_enable_o, lower_window_o,
		upper_window_o, lim_min_time_o, lim_max_time_o};

	// Clock of 50 ns period.
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// Works out the outputs that a given pair of register values must give.
	function automatic logic [51:0] expect_of(input logic off, input rcr_pkg::rcr_operating_config_word_t o,
			input rcr_pkg::rcr_limit_t l);
		logic [3:0] sc;
		sc = 4'h8 >> o.baud_range_select;
		return {off, o.baud_range_select, sc, 4'(3 * o.bit_verify_code), o.modulation_select,
			o.sleep_count, o.sleep_multiplier ? 4'h8 : 4'h1, o.squelch_enable, l.lower_window,
			l.upper_window, 9'(l.lower_window) * 9'(sc), (9'(l.upper_window) - 9'h001) * 9'(sc)};
	endfunction

	// Compares and counts one result.
	task automatic check(input logic [51:0] got, input logic [51:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Notes the expected result, then sends the word.
	task automatic prog(input logic sel, input logic [11:0] pay, input logic stop);
		if (!stop) begin
			if (sel)
				op_m = pay;
			else
				lim_m = pay;
			exp_q.push_back(expect_of(1'b0, op_m, lim_m));
		end
		host_u.send({1'b0, sel, pay, stop}, $urandom_range(2));
		// Lets the accept pulse pass, since it aborts a poll start in its cycle.
		@(negedge sys_clk_i);
	endtask

	// Sends an off command with the given select and payload bits.
	task automatic off_word(input logic [13:0] rest);
		exp_q.push_back(expect_of(1'b1, op_m, lim_m));
		host_u.send({1'b1, rest}, 0);
	endtask

	// Pulses poll done, stream end and bit check ok for one cycle.
	task automatic strobe(input logic [2:0] m);
		{poll_done_i, stream_end_i, bit_check_ok_i} = m;
		@(negedge sys_clk_i);
		{poll_done_i, stream_end_i, bit_check_ok_i} = 3'h0;
	endtask

	// Counts cycles to the next poll start, failing the run if lim passes.
	task automatic wait_poll(input int lim);
		n = 0;
		while (poll_start_o !== 1'b1) begin
			@(negedge sys_clk_i);
			n++;
			if (n >= lim) begin
				failures++;
				close_out();
			end
		end
	endtask

	// Prints the counts and the verdict and ends the run.
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Each committed word or off command is compared with the oldest note.
	always @(negedge sys_clk_i) begin
		if (word_accept_o === 1'b1 || off_cmd_o === 1'b1)
			check(seen, (exp_q.size() > 0) ? exp_q.pop_front() : 52'h0);
	end

	// Main sequence.
	initial begin
		failures = 0;
		checks_done = 0;
		sys_rst_i = 1'b1;
		{poll_done_i, stream_end_i, bit_check_ok_i} = 3'h0;
		void'($urandom(32'hCD02));
		op_m = rcr_pkg::rcr_operating_config_word_t'{2'h0, 2'h1, 1'b0, 5'h06, 1'b0, 1'b1};
		lim_m = rcr_pkg::rcr_limit_t'{6'h15, 6'h29};
		repeat (12) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		check(seen, expect_of(1'b0, op_m, lim_m));
		$display("test defaults done");
		for (int i = 0; i < 4; i++)
			prog(1'b1, {2'(i), 2'(3 - i), 1'(i), 5'($urandom_range(30, 1)), 1'(i >> 1), 1'(~i)}, 1'b0);
		prog(1'b0, 12'hFFF, 1'b0);
		prog(1'b0, 12'h04C, 1'b0);
		repeat (3) prog(1'b0, {6'($urandom_range(63, 1)), 6'($urandom_range(63, 12))}, 1'b0);
		prog(1'b1, 12'h7FF, 1'b1);
		off_word(14'($urandom));
		repeat (3) @(negedge sys_clk_i);
		check(52'(exp_q.size()), 52'h0);
		$display("test words done");
		prog(1'b1, 12'h005, 1'b0);
		strobe(3'b100);
		wait_poll(1100);
		check(52'(n > 1015 && n < 1035), 52'h1);
		prog(1'b1, 12'h001, 1'b0);
		strobe(3'b100);
		wait_poll(3);
		check(52'(n), 52'h0);
		prog(1'b1, 12'h0FD, 1'b0);
		strobe(3'b100);
		n = 0;
		repeat (1100) begin
			@(negedge sys_clk_i);
			n += (poll_start_o !== 1'b0 || sleeping_o !== 1'b1 || tick_o !== 1'b1);
		end
		check(52'(n), 52'h0);
		off_word(14'h0000);
		@(negedge sys_clk_i);
		check(52'(sleeping_o), 52'h0);
		$display("test sleep done");
		strobe(3'b001);
		check(52'({rx_mode_o, data_hold_high_o}), 52'h2);
		@(negedge sys_clk_i);
		strobe(3'b010);
		check(52'({rx_mode_o, data_hold_high_o}), 52'h1);
		@(negedge sys_clk_i);
		strobe(3'b001);
		prog(1'b1, 12'h018, 1'b0);
		strobe(3'b010);
		check(52'({rx_mode_o, data_hold_high_o}), 52'h2);
		$display("test squelch done");
		close_out();
	end
endmodule
